/* File: rcs_pkg.sv */
// Constants shared by the reset and clock start-up sequencer.
package rcs_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 20;
	localparam int OSCD_FAST_RC_NS = 1100;
	localparam int OSCD_LOW_RC_NS = 70000;
	localparam int OSCD_XTAL_NS = 1100;
	localparam int PLL_LOCK_NS = 1500000;
	localparam int OST_PERIODS = 1024;
	localparam int CNT_W = 16;
	localparam logic [15:0] OSCD_FAST_RC_CYC =
		16'(OSCD_FAST_RC_NS * CLK_MHZ / 1000);
	localparam logic [15:0] OSCD_LOW_RC_CYC =
		16'(OSCD_LOW_RC_NS * CLK_MHZ / 1000);
	localparam logic [15:0] OSCD_XTAL_CYC =
		16'(OSCD_XTAL_NS * CLK_MHZ / 1000);
	localparam int PLL_LOCK_CYC = PLL_LOCK_NS * CLK_MHZ / 1000;
	localparam logic [15:0] OST_TICKS = 16'(OST_PERIODS);

	// ****************************************************************
	// Oscillator selection codes
	// ****************************************************************
	localparam logic [2:0] SEL_FAST_RC = 3'h0;
	localparam logic [2:0] SEL_FAST_RC_PLL = 3'h1;
	localparam logic [2:0] SEL_PRI = 3'h2;
	localparam logic [2:0] SEL_PRI_PLL = 3'h3;
	localparam logic [2:0] SEL_SEC = 3'h4;
	localparam logic [2:0] SEL_LOW_RC = 3'h5;
	localparam logic [2:0] SEL_FAST_RC_DIV16 = 3'h6;
	localparam logic [2:0] SEL_FAST_RC_DIVN = 3'h7;
	localparam logic [1:0] PRI_EXT_CLOCK = 2'h0;
	localparam logic [1:0] PRI_CRYSTAL = 2'h1;
	localparam logic [1:0] PRI_FAST_CRYSTAL = 2'h2;

	// ****************************************************************
	// Configuration word fields
	// ****************************************************************
	localparam int CFG_NEW_SEL_LSB = 0;
	localparam int CFG_PRI_MODE_LSB = 3;
	localparam logic [2:0] CFG_RESET_SEL = SEL_FAST_RC;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [7:0] ADDR_OSC_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_SEQ_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_SEQ_STATUS = 8'h08;
	localparam int CUR_SEL_LSB = 12;
	localparam int SW_RESET_BIT = 0;
	localparam int STAT_IN_RESET_BIT = 0;
	localparam int STAT_COLD_BIT = 1;
	localparam int STAT_PHASE_LSB = 4;

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_OSCD,
		ST_OST,
		ST_LOCK,
		ST_RUN
	} rcs_state_e;

endpackage

/* File: rcs_delay_counter.sv */
// Phase counter: counts steps up to a target and flags the last one.
`timescale 1ns/10ps
`default_nettype none
module rcs_delay_counter #(
	parameter int W = 16
) (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic clear, // Restart the count from zero.
	input wire logic step, // Count one step.
	input wire logic [W-1:0] target, // Steps in this phase.
	output logic done // Last step of the phase is taken now.
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		if (clear) begin
			count_next = '0;
		end else if (step) begin
			count_next = count_reg + W'(1);
		end else begin
			count_next = count_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// Done must not look at clear: clear is built from the state that done
	// steers, and reading it here would close a combinational loop.
	assign done = step && (count_reg == target - W'(1));
endmodule
`default_nettype wire

/* File: rcs_sequencer.sv */
// Reset and clock start-up sequencer with an AHB-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
module rcs_sequencer
	import rcs_pkg::*;
#(
	parameter int LOCK_CYCLES = PLL_LOCK_CYC
) (
	input wire logic hclk, // System clock, 20 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready in.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Response, always OKAY.
	output logic [31:0] hrdata, // Read data.
	input wire logic por_detect, // Power-on detected, pulse.
	input wire logic brown_out_reset, // Brown-out detected, pulse.
	input wire logic warm_reset_req, // Other reset source, pulse.
	input wire logic supply_stable, // Supplies at proper level.
	input wire logic osc_tick, // One pulse per oscillator period.
	input wire logic [15:0] osc_config_word, // Nonvolatile config.
	output logic [2:0] current_osc_select, // Clock source in use.
	output logic sys_reset_n // Internal reset, active low.
);
	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_addr_next;
	logic sw_reset;
	logic addr_ok;
	rcs_state_e state_reg;
	rcs_state_e state_next;
	logic cold_reg;
	logic cold_next;
	logic [2:0] sel_reg;
	logic [2:0] sel_next;

	assign addr_ok = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign sw_reset = wr_pend_reg && (wr_addr_reg == ADDR_SEQ_CONTROL) &&
		hwdata[SW_RESET_BIT];

	always_comb begin
		wr_pend_next = addr_ok && hwrite;
		wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
		hrdata_next = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			unique case (haddr[7:0])
				ADDR_OSC_CONTROL:
					hrdata_next[CUR_SEL_LSB +: 3] = sel_reg;
				ADDR_SEQ_STATUS: begin
					hrdata_next[STAT_IN_RESET_BIT] = !sys_reset_n;
					hrdata_next[STAT_COLD_BIT] = cold_reg;
					hrdata_next[STAT_PHASE_LSB +: 3] = state_reg;
				end
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hrdata_reg <= hrdata_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
		end
	end

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	logic cold_evt;
	logic rst_evt;
	logic [1:0] pri_mode;
	logic is_fast_rc;
	logic is_xtal;
	logic is_ext;
	logic use_pll;
	logic has_oscd;
	logic has_ost;
	logic [15:0] oscd_cyc;
	logic [15:0] target;
	logic step;
	logic clear;
	logic done;

	assign cold_evt = por_detect || brown_out_reset;
	assign rst_evt = cold_evt || warm_reset_req || sw_reset;
	assign pri_mode = osc_config_word[CFG_PRI_MODE_LSB +: 2];
	assign is_fast_rc = (sel_reg == SEL_FAST_RC) ||
		(sel_reg == SEL_FAST_RC_PLL) ||
		(sel_reg == SEL_FAST_RC_DIV16) ||
		(sel_reg == SEL_FAST_RC_DIVN);
	assign is_ext = ((sel_reg == SEL_PRI) || (sel_reg == SEL_PRI_PLL)) &&
		(pri_mode == PRI_EXT_CLOCK);
	assign is_xtal = (((sel_reg == SEL_PRI) || (sel_reg == SEL_PRI_PLL)) &&
		!is_ext) || (sel_reg == SEL_SEC);
	assign use_pll = (sel_reg == SEL_FAST_RC_PLL) ||
		(sel_reg == SEL_PRI_PLL);
	assign has_oscd = !is_ext;
	assign has_ost = is_xtal;
	assign oscd_cyc = is_fast_rc ? OSCD_FAST_RC_CYC :
		(sel_reg == SEL_LOW_RC) ? OSCD_LOW_RC_CYC :
		OSCD_XTAL_CYC;

	// ****************************************************************
	// Start-up sequence
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		cold_next = cold_reg;
		sel_next = sel_reg;
		if (rst_evt) begin
			state_next = ST_HOLD;
			cold_next = cold_evt;
			if (cold_evt) begin
				sel_next = osc_config_word[CFG_NEW_SEL_LSB +: 3];
			end
			// A warm event leaves sel_reg untouched.
		end else begin
			unique case (state_reg)
				ST_HOLD: begin
					if (supply_stable) begin
						state_next = has_oscd ? ST_OSCD : has_ost ? ST_OST :
							use_pll ? ST_LOCK : ST_RUN;
					end
				end
				ST_OSCD: begin
					if (done) begin
						state_next = has_ost ? ST_OST :
							use_pll ? ST_LOCK : ST_RUN;
					end
				end
				ST_OST: begin
					if (done) begin
						state_next = use_pll ? ST_LOCK : ST_RUN;
					end
				end
				ST_LOCK: begin
					if (done) begin
						state_next = ST_RUN;
					end
				end
				ST_RUN: state_next = ST_RUN;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_HOLD;
			cold_reg <= 1'b1;
			sel_reg <= CFG_RESET_SEL;
		end else begin
			state_reg <= state_next;
			cold_reg <= cold_next;
			sel_reg <= sel_next;
		end
	end

	// The timer phase counts oscillator periods, the others clock cycles.
	assign step = (state_reg == ST_OST) ? osc_tick :
		(state_reg == ST_OSCD) || (state_reg == ST_LOCK);
	assign clear = rst_evt || (state_next != state_reg);
	assign target = (state_reg == ST_OST) ? OST_TICKS :
		(state_reg == ST_LOCK) ? 16'(LOCK_CYCLES) : oscd_cyc;

	rcs_delay_counter #(
		.W(CNT_W)
	) u_phase_cnt (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(clear),
		.step(step),
		.target(target),
		.done(done)
	);

	assign sys_reset_n = (state_reg == ST_RUN);
	assign current_osc_select = sel_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [15:0] ticks_reg;
	logic [15:0] cyc_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ticks_reg <= 16'h0000;
			cyc_reg <= 16'h0000;
		end else begin
			ticks_reg <= clear ? 16'h0000 : ticks_reg + 16'(step);
			cyc_reg <= clear ? 16'h0000 : cyc_reg + 16'h0001;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_cold_class;
		cold_evt |=> cold_reg && state_reg == ST_HOLD;
	endproperty
	a_cold_class: assert property (p_cold_class)
		else $error("cold event not recorded as cold reset");

	property p_cold_sel;
		cold_evt |=> sel_reg == $past(osc_config_word[2:0]);
	endproperty
	a_cold_sel: assert property (p_cold_sel)
		else $error("cold reset did not take configured source");

	property p_warm_keep;
		(rst_evt && !cold_evt) |=> !cold_reg && $stable(sel_reg);
	endproperty
	a_warm_keep: assert property (p_warm_keep)
		else $error("warm reset changed clock source");

	property p_hold_supply;
		(state_reg == ST_HOLD && !supply_stable) |=> !sys_reset_n;
	endproperty
	a_hold_supply: assert property (p_hold_supply)
		else $error("reset released with supplies unstable");

	property p_ost_count;
		(state_reg == ST_OST && state_next != ST_OST && !rst_evt) |->
			osc_tick && ticks_reg == OST_TICKS - 16'h0001;
	endproperty
	a_ost_count: assert property (p_ost_count)
		else $error("start-up timer left early or late");

	property p_lock_only_pll;
		state_reg == ST_LOCK |-> use_pll;
	endproperty
	a_lock_only_pll: assert property (p_lock_only_pll)
		else $error("lock wait used without PLL");

	property p_order;
		(state_reg == ST_OST && state_next != ST_OST && !rst_evt) |=>
			state_reg == (use_pll ? ST_LOCK : ST_RUN);
	endproperty
	a_order: assert property (p_order)
		else $error("phase order broken after start-up timer");

	property p_fast_rc_oscd;
		(state_reg == ST_OSCD && is_fast_rc && state_next != ST_OSCD &&
			!rst_evt) |-> cyc_reg == OSCD_FAST_RC_CYC - 16'h0001;
	endproperty
	a_fast_rc_oscd: assert property (p_fast_rc_oscd)
		else $error("fast RC start-up delay wrong length");

	property p_no_ost_rc;
		(state_reg == ST_OST) |-> !is_fast_rc &&
			sel_reg != SEL_LOW_RC && !is_ext;
	endproperty
	a_no_ost_rc: assert property (p_no_ost_rc)
		else $error("start-up timer used for RC or external clock");

	property p_restart;
		rst_evt |=> state_reg == ST_HOLD && cyc_reg == 16'h0000 &&
			ticks_reg == 16'h0000;
	endproperty
	a_restart: assert property (p_restart)
		else $error("new reset did not restart the sequence");
endmodule
`default_nettype wire

/* File: rcs_osc_model.sv */
// Oscillator model: one tick pulse per oscillator period.
`timescale 1ns/10ps
`default_nettype none
module rcs_osc_model (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic [3:0] period, // Oscillator period in clocks.
	output logic osc_tick // One pulse per period.
);
	logic [3:0] phase_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= 4'h0;
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= (phase_reg == 4'h0);
			if (phase_reg + 4'h1 >= period) begin
				phase_reg <= 4'h0;
			end else begin
				phase_reg <= phase_reg + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the reset and clock start-up sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import rcs_pkg::*;
;
	localparam int LOCK = 20;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, sys_reset_n, osc_tick;
	logic [31:0] hrdata;
	logic por = 1'b0, brown = 1'b0, warm = 1'b0, supply = 1'b0;
	logic [15:0] cfg = 16'h0;
	logic [2:0] cur_sel, exp_sel;
	logic [3:0] period = 4'h2;
	logic exp_cold;
	logic [31:0] seed = 32'h76045CFF;
	int fail_count = 0, check_count = 0, cycles = 0;

	rcs_sequencer #(.LOCK_CYCLES(LOCK)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.por_detect(por), .brown_out_reset(brown), .warm_reset_req(warm),
		.supply_stable(supply), .osc_tick(osc_tick), .osc_config_word(cfg),
		.current_osc_select(cur_sel), .sys_reset_n(sys_reset_n));
	rcs_osc_model osc (.hclk(hclk), .hresetn(hresetn), .period(period),
		.osc_tick(osc_tick));

	always #25 hclk = ~hclk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// ****************************************************************
	// Compare and bus tasks
	// ****************************************************************
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rng(string what, int lo, int hi, int got);
		check_count++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic bus(logic wr, logic [31:0] a, logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// ****************************************************************
	// Reference model of the hold time
	// ****************************************************************
	function automatic int hold_cyc(logic [2:0] s, logic [1:0] pri);
		int n;
		int ost;
		ost = 1024 * int'(period);
		n = 1;
		if (s == SEL_LOW_RC) n += int'(OSCD_LOW_RC_CYC);
		else if (s == SEL_SEC) n += int'(OSCD_XTAL_CYC) + ost;
		else if (s == SEL_PRI || s == SEL_PRI_PLL) begin
			if (pri != PRI_EXT_CLOCK) n += int'(OSCD_XTAL_CYC) + ost;
		end else n += int'(OSCD_FAST_RC_CYC);
		if (s == SEL_FAST_RC_PLL || s == SEL_PRI_PLL) n += LOCK;
		return n;
	endfunction

	// Source 0 power-on, 1 brown-out, 2 warm pin, 3 software, 4 none.
	task automatic reset_seq(int src, logic [15:0] c, int cut);
		int n;
		int e;
		logic [31:0] rd;
		@(posedge hclk);
		cfg <= c;
		supply <= 1'b0;
		if (src == 3) bus(1'b1, 32'h4, 32'h1, rd);
		else if (src < 3) begin
			@(posedge hclk);
			por <= (src == 0);
			brown <= (src == 1);
			warm <= (src == 2);
			@(posedge hclk);
			por <= 1'b0;
			brown <= 1'b0;
			warm <= 1'b0;
		end
		if (src < 2) exp_sel = c[2:0];
		if (src < 4) exp_cold = (src < 2);
		repeat (2) @(posedge hclk);
		chk("held", 32'h0, {31'h0, sys_reset_n});
		repeat (int'(rnd() % 4) + 1) @(posedge hclk);
		supply <= 1'b1;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			warm <= (n == cut);
			if (n == cut) begin
				n = 0;
				cut = 0;
				exp_cold = 1'b0;
			end
		end while (sys_reset_n !== 1'b1 && n < 6000);
		e = hold_cyc(exp_sel, c[4:3]);
		chk_rng("hold", e - 3 - int'(period), e + 3 + int'(period), n);
		chk("select", {29'h0, exp_sel}, {29'h0, cur_sel});
		bus(1'b0, 32'h0, 32'h0, rd);
		chk("osc control", {17'h0, exp_sel, 12'h0}, rd);
		bus(1'b0, 32'h8, 32'h0, rd);
		chk("status", {25'h0, 3'h4, 2'h0, exp_cold, 1'b0}, rd);
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 90000) begin
			fail_count++;
			conclude();
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [31:0] rd;
		logic [2:0] s;
		logic [1:0] p;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		exp_sel = SEL_FAST_RC;
		exp_cold = 1'b1;
		reset_seq(4, 16'h0011, 0);
		for (int i = 0; i < 14; i++) begin
			s = (i < 8) ? 3'(i) : 3'(2 + i % 2);
			p = (i < 8) ? 2'(rnd() % 3) : 2'((i - 8) / 2);
			period <= 4'(2 + rnd() % 2);
			reset_seq(i % 2, {11'h0, p, s}, 0);
		end
		reset_seq(2, 16'h0008, 0);
		reset_seq(3, 16'h000C, 0);
		reset_seq(1, 16'h000D, 300);
		bus(1'b1, 32'h0C, 32'hFFFFFFFF, rd);
		bus(1'b0, 32'h0C, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		bus(1'b0, 32'h4, 32'h0, rd);
		chk("control", 32'h0, rd);
		chk("run", 32'h1, {31'h0, sys_reset_n});
		conclude();
	end
endmodule
`default_nettype wire
